// ### logic/crl_pkg.sv
package crl_pkg;
  // Widths of the word, storage address and short index
  localparam int ADDR_W = 17;
  localparam int WORD_W = 30;
  localparam int DBL_W = 60;
  localparam int IDX_SHORT_W = 15;
  localparam int IDX_PER_SET = 7;
  localparam int IDX_COUNT = 14;
  localparam int HALF_W = 15;
  localparam int REG_ADR_W = 8;

  // Register byte offsets on the register bus
  localparam logic [7:0] PLC_OFS = 8'h00;
  localparam logic [7:0] BASE_OFS = 8'h04;
  localparam logic [7:0] LOWER_OFS = 8'h08;
  localparam logic [7:0] UPPER_OFS = 8'h0c;
  localparam logic [7:0] IFW_OFS = 8'h10;
  localparam logic [7:0] SSR_OFS = 8'h14;
  localparam logic [7:0] ACC_OFS = 8'h18;
  localparam logic [7:0] PART_OFS = 8'h1c;
  localparam logic [7:0] STAT_OFS = 8'h20;
  localparam logic [7:0] MASK_OFS = 8'h24;
  localparam logic [7:0] FMT_OFS = 8'h28;
  localparam logic [7:0] ADD_OFS = 8'h2c;
  localparam logic [7:0] HADD_OFS = 8'h30;
  localparam logic [7:0] IDX_OFS = 8'h40;

  // Function word field positions
  localparam int IFW_SPLIT_BIT = 0;
  localparam int IFW_LEN_BIT = 1;
  localparam int IFW_BIAS_BIT = 2;
  localparam int IFW_SET_BIT = 3;
  localparam int IFW_GUARD_BIT = 4;
  localparam int IFW_MODE_LSB = 5;

  // Status and mask bit positions
  localparam int ST_VIOL = 0;
  localparam int ST_REFUSE = 1;
  localparam int ST_UNSUP = 2;
  localparam int ST_W = 3;

  // Values after reset
  localparam logic [16:0] PLC_RST = 17'h00000;
  localparam logic [16:0] BASE_RST = 17'h00000;
  localparam logic [16:0] LOWER_RST = 17'h00000;
  localparam logic [16:0] UPPER_RST = 17'h1ffff;
  localparam logic [29:0] IFW_RST = 30'h00000000;
  localparam logic [29:0] WORD_RST = 30'h00000000;
  localparam logic [2:0] STAT_RST = 3'h0;

  // Arithmetic mode held in the function word
  typedef enum logic [1:0] {
    MODE_BIN_SINGLE, MODE_BIN_DOUBLE, MODE_DECIMAL, MODE_FLOAT
  } crl_mode_t;

  // Access request from the instruction sequencer
  typedef struct packed {
    logic valid;
    logic data;
    logic restricted;
    logic [2:0] idx;
    logic [16:0] y;
  } crl_acc_t;

  // Request towards primary storage
  typedef struct packed {
    logic req;
    logic instr;
    logic [16:0] addr;
  } crl_stor_t;
endpackage : crl_pkg

// ### logic/crl_core.sv
// Our own choices: the register addresses and register access over Wishbone.
module crl_core #(
  parameter int SSR_W = 4
) (
  input wire logic SYS_CLK_I, // 40 MHz clock
  input wire logic NRST_I, // Async reset, active low
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Bus strobe
  input wire logic WB_WE_I, // Bus write
  input wire logic [crl_pkg::REG_ADR_W-1:0] WB_ADR_I, // Byte address
  input wire logic [3:0] WB_SEL_I, // Byte enables
  input wire logic [31:0] WB_DAT_I, // Write data
  output logic [31:0] WB_DAT_O, // Read data
  output logic WB_ACK_O, // Bus acknowledge
  input wire crl_pkg::crl_acc_t ACC_I, // Access request
  output crl_pkg::crl_stor_t STOR_O, // Storage request
  output logic REFUSE_O, // Access refused pulse
  output logic [SSR_W-1:0] MOD_SEL_O, // Storage module select
  output logic IRQ_O // Interrupt level
);
  import crl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (SSR_W < 1 || SSR_W > 30) begin : g_bad_ssr
    $error("crl_core: SSR_W must be 1 to 30");
  end

  // Byte-lane merge for bus writes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // Index value trimmed to its operating length
  function automatic logic [16:0] idx_len(input logic [16:0] v,
      input logic [2:0] n, input logic len_opt);
    if (!len_opt || n <= 3'h3) begin
      return {2'h0, v[IDX_SHORT_W-1:0]};
    end
    return v;
  endfunction : idx_len

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [16:0] pc;
  logic [16:0] base;
  logic [16:0] lower;
  logic [16:0] upper;
  logic [29:0] ifw;
  logic [SSR_W-1:0] ssr;
  logic [29:0] acc;
  logic [29:0] part;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [16:0] idx_reg [IDX_COUNT];

  // Bus decode
  logic wb_go;
  logic wr;
  logic [7:0] a;
  logic idx_hit;
  logic [3:0] idx_n;
  assign wb_go = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr = wb_go && WB_WE_I;
  assign a = {WB_ADR_I[7:2], 2'h0};
  assign idx_hit = (a >= IDX_OFS) && (a < IDX_OFS + 8'(4 * IDX_COUNT));
  assign idx_n = 4'((a - IDX_OFS) >> 2);

  // Function word fields
  logic guard;
  logic wset;
  crl_mode_t mode;
  assign guard = ifw[IFW_GUARD_BIT];
  // Guarded programs can never reach the executive set
  assign wset = guard ? 1'b1 : ifw[IFW_SET_BIT];
  assign mode = crl_mode_t'(ifw[IFW_MODE_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////
  // Effective address and protection checks
  logic [3:0] entry;
  logic [16:0] ival;
  logic [16:0] off;
  logic [16:0] bias;
  logic [16:0] eff;
  logic fault_lim;
  logic fault_res;
  logic take;
  always_comb begin
    entry = 4'h0;
    if (ACC_I.idx != 3'h0) begin
      entry = wset ? 4'(ACC_I.idx) + 4'(IDX_PER_SET - 1)
                   : 4'(ACC_I.idx) - 4'h1;
    end
    ival = idx_len(idx_reg[entry], ACC_I.idx, ifw[IFW_LEN_BIT]);
    if (!ACC_I.data) begin
      off = pc;
      bias = base;
    end else if (ACC_I.idx != 3'h0) begin
      off = 17'(ACC_I.y + ival);
      // Bias option splits the set between base and lower limit
      bias = (ifw[IFW_BIAS_BIT] && ACC_I.idx > 3'h3) ? lower : base;
    end else begin
      off = ACC_I.y;
      bias = ifw[IFW_SPLIT_BIT] ? lower : base;
    end
    eff = 17'(off + bias);
    fault_res = guard && ACC_I.restricted;
    fault_lim = guard && (eff < lower || eff > upper);
  end
  assign take = ACC_I.valid;

  // Storage request; only fetches and operands go out
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      STOR_O <= '0;
      REFUSE_O <= 1'b0;
    end else begin
      STOR_O.req <= take && !fault_res && !fault_lim;
      STOR_O.instr <= !ACC_I.data;
      STOR_O.addr <= eff;
      REFUSE_O <= take && (fault_res || fault_lim);
    end
  end

  // Program counter: bus load, else step on each accepted fetch
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pc <= PLC_RST;
    end else if (wr && a == PLC_OFS) begin
      pc <= 17'(merge(32'(pc), WB_DAT_I, WB_SEL_I));
    end else if (take && !ACC_I.data && !fault_res && !fault_lim) begin
      pc <= 17'(pc + 17'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Relocation, limits, function word and storage select
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      base <= BASE_RST;
      lower <= LOWER_RST;
      upper <= UPPER_RST;
      ifw <= IFW_RST;
      ssr <= '0;
      mask <= '0;
    end else if (wr) begin
      unique case (a)
        BASE_OFS: base <= 17'(merge(32'(base), WB_DAT_I, WB_SEL_I));
        LOWER_OFS: lower <= 17'(merge(32'(lower), WB_DAT_I, WB_SEL_I));
        UPPER_OFS: upper <= 17'(merge(32'(upper), WB_DAT_I, WB_SEL_I));
        IFW_OFS: ifw <= 30'(merge(32'(ifw), WB_DAT_I, WB_SEL_I));
        SSR_OFS: ssr <= SSR_W'(merge(32'(ssr), WB_DAT_I, WB_SEL_I));
        MASK_OFS: mask <= ST_W'(merge(32'(mask), WB_DAT_I, WB_SEL_I));
        default: ;
      endcase
    end
  end

  // Module select follows the manual select register
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      MOD_SEL_O <= '0;
    end else begin
      MOD_SEL_O <= ssr;
    end
  end

  // Index registers, two sets of seven
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < IDX_COUNT; i++) begin
        idx_reg[i] <= '0;
      end
    end else if (wr && idx_hit) begin
      idx_reg[idx_n] <= 17'(merge(32'(idx_reg[idx_n]), WB_DAT_I,
                                  WB_SEL_I));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator and partner; adds by the mode in the function word
  logic add_wr;
  logic hadd_wr;
  logic unsup;
  assign add_wr = wr && a == ADD_OFS;
  assign hadd_wr = wr && a == HADD_OFS;
  // Decimal and floating arithmetic live in another unit
  assign unsup = add_wr && (mode == MODE_DECIMAL || mode == MODE_FLOAT);
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      acc <= WORD_RST;
      part <= WORD_RST;
    end else if (wr && a == ACC_OFS) begin
      acc <= 30'(merge(32'(acc), WB_DAT_I, WB_SEL_I));
    end else if (wr && a == PART_OFS) begin
      part <= 30'(merge(32'(part), WB_DAT_I, WB_SEL_I));
    end else if (add_wr && mode == MODE_BIN_SINGLE) begin
      acc <= 30'(acc + WB_DAT_I[29:0]);
    end else if (add_wr && mode == MODE_BIN_DOUBLE) begin
      // Operand is sign-extended into the high word
      {acc, part} <= 60'({acc, part} +
          {{WORD_W{WB_DAT_I[29]}}, WB_DAT_I[29:0]});
    end else if (hadd_wr) begin
      // Halves add apart; no carry passes from bit 14 into bit 15
      acc[29:15] <= 15'(acc[29:15] + WB_DAT_I[29:15]);
      acc[14:0] <= 15'(acc[14:0] + WB_DAT_I[14:0]);
    end
  end

  // Sign view: single/double sign, lower half sign, double zero
  logic [3:0] fmt;
  assign fmt = {1'b0, ({acc, part} == '0), acc[HALF_W-1],
                acc[WORD_W-1]};

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear; a new event wins
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;
  assign ev = {unsup, take && fault_res, take && fault_lim && !fault_res};
  assign clr = (wr && a == STAT_OFS) ? WB_DAT_I[ST_W-1:0] & {ST_W{WB_SEL_I[0]}}
                                     : '0;
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      status <= STAT_RST;
    end else begin
      status <= (status & ~clr) | ev;
    end
  end

  // Interrupt level from unmasked status
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus read mux; unmapped addresses read zero
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (idx_hit) begin
      rdata = 32'(idx_reg[idx_n]);
    end else begin
      unique case (a)
        PLC_OFS: rdata = 32'(pc);
        BASE_OFS: rdata = 32'(base);
        LOWER_OFS: rdata = 32'(lower);
        UPPER_OFS: rdata = 32'(upper);
        IFW_OFS: rdata = 32'(ifw);
        SSR_OFS: rdata = 32'(ssr);
        ACC_OFS: rdata = 32'(acc);
        PART_OFS: rdata = 32'(part);
        STAT_OFS: rdata = 32'(status);
        MASK_OFS: rdata = 32'(mask);
        FMT_OFS: rdata = 32'(fmt);
        default: rdata = 32'h0;
      endcase
    end
  end

  // Single-wait acknowledge; ack drops the cycle after
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wb_go;
      if (wb_go && !WB_WE_I) begin
        WB_DAT_O <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  logic plain_fetch;
  assign plain_fetch = take && !ACC_I.data && !fault_res && !fault_lim;

  chk_pc_step: assert property (
    plain_fetch && !(wr && a == PLC_OFS) |=> pc == 17'($past(pc) + 17'h1))
    else $error("program counter did not step");

  chk_fetch_reloc: assert property (
    plain_fetch |=> STOR_O.req && STOR_O.instr &&
        STOR_O.addr == 17'($past(pc) + $past(base)))
    else $error("fetch address not relocated by base");

  chk_split_data: assert property (
    take && ACC_I.data && ACC_I.idx == 3'h0 && ifw[IFW_SPLIT_BIT] &&
        !fault_res && !fault_lim
    |=> STOR_O.req && STOR_O.addr == 17'($past(ACC_I.y) + $past(lower)))
    else $error("split mode data not biased by lower limit");

  chk_guard_refuse: assert property (
    take && guard && ACC_I.restricted |=> REFUSE_O && !STOR_O.req ##1
        status[ST_REFUSE])
    else $error("restricted op not refused in guard state");

  chk_limit_window: assert property (
    STOR_O.req && $past(guard) |->
        STOR_O.addr >= $past(lower) && STOR_O.addr <= $past(upper))
    else $error("guarded access escaped the limits");

  chk_viol_flag: assert property (
    take && fault_lim && !fault_res |=> REFUSE_O ##1 status[ST_VIOL][*2])
    else $error("limit fault not flagged");

  chk_worker_set: assert property (
    take && guard && ACC_I.idx == 3'h1 |-> entry == 4'(IDX_PER_SET))
    else $error("guarded program reached executive set");

  chk_short_index: assert property (
    take && ACC_I.idx != 3'h0 && !ifw[IFW_LEN_BIT] |-> ival[16:15] == 2'h0)
    else $error("index not trimmed to 15 bits");

  chk_double_add: assert property (
    add_wr && mode == MODE_BIN_DOUBLE |=>
        {acc, part} == 60'($past({acc, part}) +
        {{WORD_W{$past(WB_DAT_I[29])}}, $past(WB_DAT_I[29:0])}))
    else $error("double length add wrong");

  chk_select_out: assert property (
    $changed(ssr) |=> MOD_SEL_O == $past(ssr))
    else $error("module select did not follow register");

  cov_fetch: cover property (plain_fetch ##1 STOR_O.req);
  cov_data_index: cover property (take && ACC_I.data && ACC_I.idx > 3'h3);
  cov_violation: cover property (take && fault_lim ##2 IRQ_O);
  cov_double_add: cover property (add_wr && mode == MODE_BIN_DOUBLE);
endmodule : crl_core

// ### verification/crl_stor_model.sv
// Primary storage seen from the core: records each request
module crl_stor_model (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Reset, active low
  input wire crl_pkg::crl_stor_t stor_i, // Storage request
  output logic [16:0] last_addr_o, // Address of last request
  output logic last_instr_o, // Last request was a fetch
  output logic [15:0] req_cnt_o // Requests taken
);
  timeunit 1ns;
  timeprecision 1ps;
  import crl_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Core storage has no stall path, so every pulse is one access
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_addr_o <= 17'h00000;
      last_instr_o <= 1'b0;
      req_cnt_o <= 16'h0000;
    end else if (stor_i.req) begin
      last_addr_o <= stor_i.addr;
      last_instr_o <= stor_i.instr;
      req_cnt_o <= req_cnt_o + 16'h0001;
    end
  end
endmodule : crl_stor_model

// ### verification/tb_cpu_register_and_relocation.sv
module tb_cpu_register_and_relocation;
  timeunit 1ns;
  timeprecision 1ps;
  import crl_pkg::*;

  logic clk, nrst, cyc, stb, we, ack, refuse, irq, m_instr;
  logic [7:0] adr;
  logic [3:0] sel, mod_sel;
  logic [31:0] wdat, rdat_w, rd;
  logic [16:0] m_addr;
  logic [15:0] m_cnt;
  crl_acc_t acc_i;
  crl_stor_t stor;
  int errors, checks_done, n_ok;
  logic [7:0] ra [0:11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
    8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h38};
  logic [31:0] re [0:11] = '{32'h0, 32'h0, 32'h0, 32'h1ffff, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h0};

  crl_core #(.SSR_W(4)) DUT (
    .SYS_CLK_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat_w), .WB_ACK_O(ack), .ACC_I(acc_i), .STOR_O(stor),
    .REFUSE_O(refuse), .MOD_SEL_O(mod_sel), .IRQ_O(irq));

  crl_stor_model stor_model (.clk_i(clk), .nrst_i(nrst), .stor_i(stor),
    .last_addr_o(m_addr), .last_instr_o(m_instr), .req_cnt_o(m_cnt));

  ////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count and report one comparison
  task chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what,
        seen, exp);
    end
  endtask : chk

  // One classic cycle; waits for ack without assuming its latency
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    // Only the watchdog ends a wait for an ack that never comes
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    // Slave answers one edge after the edge that takes the request
    chk(32'(n), 32'h2, "ack latency");
    rd = rdat_w;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0);
    chk(rd, e, s);
  endtask : rd_chk

  // One access: exactly one of store request or refusal follows
  task acc_go(input logic d, r, input logic [2:0] ix,
    input logic [16:0] y, ea, input logic rf);
    @(posedge clk);
    acc_i <= {1'b1, d, r, ix, y};
    @(posedge clk);
    acc_i <= '0;
    #1;
    chk({31'h0, refuse}, {31'h0, rf}, "refusal");
    chk({31'h0, stor.req}, {31'h0, !rf}, "store request");
    @(posedge clk);
    #1;
    if (!rf) begin
      n_ok++;
      chk({15'h0, m_addr}, {15'h0, ea}, "storage address");
      chk({31'h0, m_instr}, {31'h0, !d}, "fetch flag");
    end
  endtask : acc_go

  task test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    {cyc, stb, we, adr, sel, wdat} = '0;
    acc_i = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rd_chk(ra[i], re[i], "reset");
    end
    // Sequential fetches relocated by the base
    wr(BASE_OFS, 32'h100);
    wr(PLC_OFS, 32'h5);
    acc_go(1'b0, 1'b0, 3'd0, 17'h0, 17'h105, 1'b0);
    acc_go(1'b0, 1'b0, 3'd0, 17'h0, 17'h106, 1'b0);
    rd_chk(PLC_OFS, 32'h7, "pc step");
    // Split mode: data on lower limit, fetch stays on base
    wr(LOWER_OFS, 32'h2000);
    wr(IFW_OFS, 32'h1);
    acc_go(1'b1, 1'b0, 3'd0, 17'h10, 17'h2010, 1'b0);
    acc_go(1'b0, 1'b0, 3'd0, 17'h0, 17'h107, 1'b0);
    // Length and bias options, 17-bit value wraps the sum
    wr(IDX_OFS + 8'h0c, 32'h1ffff);
    wr(IDX_OFS, 32'h1234);
    wr(IFW_OFS, 32'h6);
    rd_chk(IFW_OFS, 32'h6, "function word");
    acc_go(1'b1, 1'b0, 3'd4, 17'h1, 17'h2000, 1'b0);
    acc_go(1'b1, 1'b0, 3'd1, 17'h10, 17'h1344, 1'b0);
    wr(IFW_OFS, 32'h4);
    acc_go(1'b1, 1'b0, 3'd4, 17'h1, 17'ha000, 1'b0);
    rd_chk(IDX_OFS + 8'h0c, 32'h1ffff, "index width");
    // Second set chosen by the set field
    wr(IDX_OFS + 8'h1c, 32'h40);
    wr(IFW_OFS, 32'h8);
    acc_go(1'b1, 1'b0, 3'd1, 17'h0, 17'h140, 1'b0);
    // Guard: worker set, refusals, limits at both edges
    wr(LOWER_OFS, 32'h100);
    wr(UPPER_OFS, 32'h1ff);
    wr(BASE_OFS, 32'h0);
    wr(MASK_OFS, 32'h3);
    wr(IFW_OFS, 32'h10);
    acc_go(1'b1, 1'b0, 3'd1, 17'h1bf, 17'h1ff, 1'b0);
    acc_go(1'b1, 1'b1, 3'd0, 17'h150, 17'h0, 1'b1);
    rd_chk(STAT_OFS, 32'h2, "refused status");
    chk({31'h0, irq}, 32'h1, "irq raised");
    acc_go(1'b1, 1'b0, 3'd0, 17'h200, 17'h0, 1'b1);
    acc_go(1'b1, 1'b0, 3'd0, 17'h0ff, 17'h0, 1'b1);
    wr(PLC_OFS, 32'h50);
    acc_go(1'b0, 1'b0, 3'd0, 17'h0, 17'h0, 1'b1);
    rd_chk(PLC_OFS, 32'h50, "pc held");
    rd_chk(STAT_OFS, 32'h3, "violation status");
    // Masking drops the line, clearing empties status
    wr(MASK_OFS, 32'h0);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(MASK_OFS, 32'h3);
    wr(STAT_OFS, 32'h3);
    rd_chk(STAT_OFS, 32'h0, "status cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(IFW_OFS, 32'h0);
    // Module select reaches the pins
    wr(SSR_OFS, 32'ha);
    @(posedge clk);
    #1;
    chk({28'h0, mod_sel}, 32'ha, "module select");
    // Binary single wraps at 30 bits
    wr(ACC_OFS, 32'h3fffffff);
    wr(ADD_OFS, 32'h2);
    rd_chk(ACC_OFS, 32'h1, "single add");
    // Double: negative addend fills both halves with sign
    wr(IFW_OFS, 32'h20);
    wr(ACC_OFS, 32'h0);
    wr(PART_OFS, 32'h0);
    wr(ADD_OFS, 32'h3fffffff);
    rd_chk(ACC_OFS, 32'h3fffffff, "double high");
    rd_chk(PART_OFS, 32'h3fffffff, "double low");
    rd_chk(FMT_OFS, 32'h3, "sign bits");
    // Half words: low carry must not reach the upper half
    wr(ACC_OFS, 32'h7fff);
    wr(HADD_OFS, 32'h1);
    rd_chk(ACC_OFS, 32'h0, "half add");
    // Decimal and floating leave the accumulator alone here
    wr(ACC_OFS, 32'h15);
    for (int m = 2; m < 4; m++) begin
      wr(IFW_OFS, 32'(m) << 5);
      wr(ADD_OFS, 32'h1);
      rd_chk(ACC_OFS, 32'h15, "mode no change");
      rd_chk(STAT_OFS, 32'h4, "mode status");
      wr(STAT_OFS, 32'h4);
    end
    chk({16'h0, m_cnt}, 32'(n_ok), "storage count");
    // Reset in mid-run: pins and registers fall back at once
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    chk({28'h0, mod_sel}, 32'h0, "select in reset");
    @(posedge clk);
    nrst <= 1'b1;
    rd_chk(PLC_OFS, 32'h0, "pc after reset");
    rd_chk(UPPER_OFS, 32'h1ffff, "upper after reset");
    rd_chk(IFW_OFS, 32'h0, "word after reset");
    rd_chk(ACC_OFS, 32'h0, "acc after reset");
    test_done;
  end
endmodule : tb_cpu_register_and_relocation
